// File: verilog/gauge_spi_port.sv
// serial command and status port of a dual gauge driver
`include "gauge_spi_params.svh"
module gauge_spi_port (
   input  wire logic                       mclk,
   input  wire logic                       resetn,
   input  wire logic                       cs_n,
   input  wire logic                       sclk,
   input  wire logic                       si,
   output logic                            so,
   output logic                            so_oe,
   input  wire logic [`WORD_W-1:0]         status_word,
   output gauge_spi_pkg::gauge_regs_t      regs,
   output logic                            commit_pulse,
   output logic [2:0]                      commit_addr
);
   import gauge_spi_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      spi_pins_t              s1;
      spi_pins_t              s2;
      logic                   sclk_d;
      logic                   cs_d;
      link_state_t            st;
      logic [`WORD_W-1:0]     rx;
      logic [`WORD_W-1:0]     tx;
      logic [`BITCNT_W-1:0]   nfall;
      logic [`BITCNT_W-1:0]   nrise;
      logic                   loaded;
      logic                   so;
      logic                   oe;
      gauge_regs_t            regs;
      logic                   commit;
      logic [2:0]             caddr;
   } port_st_t;

   port_st_t               s_q;
   port_st_t               s_d;
   logic                   rise;
   logic                   fall;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   word_done;
   logic                   f_in_ready;
   logic [`WORD_W-1:0]     f_out_data;
   logic                   f_out_valid;
   logic                   f_pop;

   // ----------------------------------------------------------------
   // edge detection on the synchronised pins
   // ----------------------------------------------------------------
   // only the second stage is looked at, the first is metastability room
   assign rise      = s_q.s2.sclk && !s_q.sclk_d && !s_q.s2.cs_n;
   assign fall      = !s_q.s2.sclk && s_q.sclk_d && !s_q.s2.cs_n;
   assign cs_fall   = !s_q.s2.cs_n && s_q.cs_d;
   assign cs_rise   = s_q.s2.cs_n && !s_q.cs_d;
   assign word_done = fall && (s_q.nfall[3:0] == 4'hf);

   // completed input words wait here until the status word is out
   assign f_pop = rise && s_q.loaded && (s_q.nrise[3:0] == 4'h0) && f_out_valid;

   word_fifo #(
      .WIDTH (`WORD_W),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .clr       (cs_fall),
      .in_data   ({s_q.rx[`WORD_W-2:0], s_q.s2.si}),
      .in_valid  (word_done),
      .in_ready  (f_in_ready),
      .out_data  (f_out_data),
      .out_valid (f_out_valid),
      .out_ready (f_pop)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d        = s_q;
      s_d.s1     = '{cs_n: cs_n, sclk: sclk, si: si};
      s_d.s2     = s_q.s1;
      s_d.sclk_d = s_q.s2.sclk;
      s_d.cs_d   = s_q.s2.cs_n;
      s_d.commit = 1'b0;
      case (s_q.st)
         ST_IDLE:
         begin
            s_d.oe = 1'b0;
            if (cs_fall)
            begin
               s_d.oe     = 1'b1;
               s_d.nfall  = '0;
               s_d.nrise  = '0;
               s_d.loaded = 1'b0;
               s_d.st     = ST_SHIFT;
            end
         end
         ST_SHIFT:
         begin
            if (fall)
            begin
               s_d.rx    = {s_q.rx[`WORD_W-2:0], s_q.s2.si};
               s_d.nfall = s_q.nfall + 1'b1;
            end
            if (rise)
            begin
               s_d.nrise = s_q.nrise + 1'b1;
               if (!s_q.loaded)
               begin
                  // status word taken at the first rise, msb out now
                  s_d.loaded = 1'b1;
                  s_d.so     = status_word[`WORD_W-1];
                  s_d.tx     = {status_word[`WORD_W-2:0], 1'b0};
               end
               else if (s_q.nrise[3:0] == 4'h0)
               begin
                  // next sixteen bits come from the received words
                  s_d.so = f_out_valid ? f_out_data[`WORD_W-1] : 1'b0;
                  s_d.tx = {f_out_data[`WORD_W-2:0], 1'b0};
               end
               else
               begin
                  s_d.so = s_q.tx[`WORD_W-1];
                  s_d.tx = {s_q.tx[`WORD_W-2:0], 1'b0};
               end
            end
            if (cs_rise)
            begin
               s_d.oe = 1'b0;
               s_d.st = ST_DONE;
            end
         end
         ST_DONE:
         begin
            // whole words only; a lone fragment changes nothing
            if ((s_q.nfall != '0) && (s_q.nfall[3:0] == 4'h0))
            begin
               s_d.commit = 1'b1;
               s_d.caddr  = s_q.rx[`ADDR_MSB:`ADDR_LSB];
               case (s_q.rx[`ADDR_MSB:`ADDR_LSB])
                  `ADDR_PECC:
                     // null command reads status without altering setup
                     if (!s_q.rx[`NULL_BIT])
                        s_d.regs.power_enable_calibration_config = s_q.rx[`DATA_W-1:0];
                  `ADDR_VEL:  s_d.regs.maximum_velocity = s_q.rx[`DATA_W-1:0];
                  `ADDR_POS0: s_d.regs.gauge0_target_position = s_q.rx[`DATA_W-1:0];
                  `ADDR_POS1: s_d.regs.gauge1_target_position = s_q.rx[`DATA_W-1:0];
                  `ADDR_ZCMD: s_d.regs.return_to_zero_command = s_q.rx[`DATA_W-1:0];
                  `ADDR_ZCFG: s_d.regs.return_to_zero_config = s_q.rx[`DATA_W-1:0];
                  `ADDR_RAMP: s_d.regs.ramp_selection = s_q.rx[`DATA_W-1:0];
                  default:    s_d.regs = s_q.regs;
               endcase
            end
            s_d.st = ST_IDLE;
         end
         default:
         begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q                                      <= '0;
         s_q.s1                                   <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
         s_q.s2                                   <= '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};
         s_q.cs_d                                 <= 1'b1;
         s_q.regs.power_enable_calibration_config <= `REG_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign so           = s_q.so;
   assign so_oe        = s_q.oe;
   assign regs         = s_q.regs;
   assign commit_pulse = s_q.commit;
   assign commit_addr  = s_q.caddr;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   oe_off_idle_a: assert property (s_q.st == ST_IDLE && !cs_fall |=> !so_oe)
      else $error("output enabled while deselected");
   oe_on_fall_a: assert property (s_q.st == ST_IDLE && cs_fall |=> so_oe)
      else $error("output not enabled after select fall");
   short_drop_a: assert property (s_q.st == ST_DONE && s_q.nfall[3:0] != 4'h0
                                  |=> !commit_pulse && $stable(regs))
      else $error("partial word changed registers");
   commit_ok_a: assert property (s_q.st == ST_DONE && s_q.nfall == 8'h10
                                 |=> commit_pulse)
      else $error("full word not committed");
   commit_after_cs_a: assert property (commit_pulse |-> $past(s_q.st == ST_DONE, 1))
      else $error("commit without select rise");
   addr_pick_a: assert property (commit_pulse && commit_addr == `ADDR_VEL
                    |-> regs.maximum_velocity == $past(s_q.rx[`DATA_W-1:0]))
      else $error("wrong register updated");
   test_code_a: assert property (commit_pulse && commit_addr == `ADDR_TEST
                                 |-> $stable(regs))
      else $error("reserved code changed registers");
   idle_quiet_a: assert property (s_q.s2.cs_n |=> $stable(s_q.rx) && $stable(s_q.nfall))
      else $error("clock activity seen while deselected");
   status_first_a: assert property (rise && !s_q.loaded
                                    |=> so == $past(status_word[`WORD_W-1]))
      else $error("status msb not presented");
   so_rise_only_a: assert property ($changed(so) |-> $past(rise))
      else $error("output changed without clock rise");
   loaded_once_a: assert property (s_q.st == ST_SHIFT && s_q.loaded |=> s_q.loaded)
      else $error("status word reloaded inside a frame");
   done_short_a: assert property (s_q.st == ST_DONE && s_q.nfall == '0 |=> !commit_pulse)
      else $error("empty frame committed");

   // ----------------------------------------------------------------
   // register map and link checks
   // ----------------------------------------------------------------
   // each code except the null command and reserved code 7 must land in its own field; only the velocity write is also checked to leave gauge 0 alone
   pecc_write_a: assert property (commit_pulse && commit_addr == `ADDR_PECC
                     && !$past(s_q.rx[`NULL_BIT])
                     |-> regs.power_enable_calibration_config == $past(s_q.rx[`DATA_W-1:0]))
      else $error("setup register not written");
   null_keep_a: assert property (commit_pulse && commit_addr == `ADDR_PECC
                     && $past(s_q.rx[`NULL_BIT]) |-> $stable(regs))
      else $error("null command changed registers");
   pos0_write_a: assert property (commit_pulse && commit_addr == `ADDR_POS0
                     |-> regs.gauge0_target_position == $past(s_q.rx[`DATA_W-1:0]))
      else $error("gauge 0 target not written");
   pos1_write_a: assert property (commit_pulse && commit_addr == `ADDR_POS1
                     |-> regs.gauge1_target_position == $past(s_q.rx[`DATA_W-1:0]))
      else $error("gauge 1 target not written");
   zcmd_write_a: assert property (commit_pulse && commit_addr == `ADDR_ZCMD
                     |-> regs.return_to_zero_command == $past(s_q.rx[`DATA_W-1:0]))
      else $error("zeroing command not written");
   zcfg_write_a: assert property (commit_pulse && commit_addr == `ADDR_ZCFG
                     |-> regs.return_to_zero_config == $past(s_q.rx[`DATA_W-1:0]))
      else $error("zeroing setup not written");
   ramp_write_a: assert property (commit_pulse && commit_addr == `ADDR_RAMP
                     |-> regs.ramp_selection == $past(s_q.rx[`DATA_W-1:0]))
      else $error("ramp selection not written");
   vel_only_a: assert property (commit_pulse && commit_addr == `ADDR_VEL
                     |-> regs.gauge0_target_position == $past(regs.gauge0_target_position))
      else $error("velocity write touched gauge 0 target");
   caddr_match_a: assert property (commit_pulse
                     |-> commit_addr == $past(s_q.rx[`ADDR_MSB:`ADDR_LSB]))
      else $error("commit address differs from received code");
   commit_once_a: assert property (commit_pulse |=> !commit_pulse)
      else $error("commit pulse longer than one cycle");
   oe_drop_a: assert property (s_q.st == ST_SHIFT && cs_rise |=> !so_oe)
      else $error("output still enabled after select rise");
   rx_sample_a: assert property (s_q.st == ST_SHIFT && fall
                     |=> s_q.rx[0] == $past(s_q.s2.si))
      else $error("input bit not taken at clock fall");
   chain_out_a: assert property (f_pop |=> so == $past(f_out_data[`WORD_W-1]))
      else $error("received word not passed on");
   fifo_room_a: assert property (word_done |-> f_in_ready)
      else $error("received word lost, fifo full");

   // ----------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------
   single_word_c: cover property (commit_pulse ##1 1'b1);
   chain_word_c: cover property (f_pop);
   short_word_c: cover property (s_q.st == ST_DONE && s_q.nfall == 8'h0f);
   reserved_c: cover property (commit_pulse && commit_addr == `ADDR_TEST);
endmodule : gauge_spi_port

// File: verilog/gauge_spi_params.svh
// constants of the gauge driver serial command port
`ifndef GAUGE_SPI_PARAMS_SVH
`define GAUGE_SPI_PARAMS_SVH
`define WORD_W        16
`define ADDR_MSB      15
`define ADDR_LSB      13
`define DATA_W        13
`define BITCNT_W      8
`define REG_RESET     13'h0000
`define ADDR_PECC     3'h0
`define ADDR_VEL      3'h1
`define ADDR_POS0     3'h2
`define ADDR_POS1     3'h3
`define ADDR_ZCMD     3'h4
`define ADDR_ZCFG     3'h5
`define ADDR_RAMP     3'h6
`define ADDR_TEST     3'h7
`define NULL_BIT      12
`define FIFO_DEPTH    8
`define FIFO_AW       3
`endif

// File: verilog/gauge_spi_pkg.sv
// types shared by the gauge driver serial command port
package gauge_spi_pkg;
`include "gauge_spi_params.svh"
   typedef struct packed {
      logic [`DATA_W-1:0] power_enable_calibration_config;
      logic [`DATA_W-1:0] maximum_velocity;
      logic [`DATA_W-1:0] gauge0_target_position;
      logic [`DATA_W-1:0] gauge1_target_position;
      logic [`DATA_W-1:0] return_to_zero_command;
      logic [`DATA_W-1:0] return_to_zero_config;
      logic [`DATA_W-1:0] ramp_selection;
   } gauge_regs_t;
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } spi_pins_t;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE  = 2'b11
   } link_state_t;
endpackage : gauge_spi_pkg

// File: verilog/word_fifo.sv
// small synchronous fifo with valid/ready on both sides
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             mclk,
   input  wire logic             resetn,
   input  wire logic             clr,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } fifo_st_t;
   fifo_st_t         s_q;
   fifo_st_t         s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             wr;
   logic             rd;

   assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_q.cnt != '0);
   assign out_data  = mem[s_q.rp];
   assign wr        = in_valid && in_ready;
   assign rd        = out_valid && out_ready;

   always_comb
   begin
      s_d = s_q;
      if (clr)
      begin
         s_d = '0;
      end
      else
      begin
         if (wr)
            s_d.wp = s_q.wp + 1'b1;
         if (rd)
            s_d.rp = s_q.rp + 1'b1;
         s_d.cnt = s_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // storage holds no reset; validity comes from the count
   always_ff @(posedge mclk)
   begin
      if (wr && !clr)
         mem[s_q.wp] <= in_data;
   end
endmodule : word_fifo

// File: sim/spi_host_model.sv
// host-side master model that drives the gauge port link
module spi_host_model (
   input  wire logic mclk,
   output logic      cs_n,
   output logic      sclk,
   output logic      si,
   input  wire logic so,
   input  wire logic so_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs_n = 1'b1;
      sclk = 1'b0;
      si   = 1'b0;
   end
   // ----
   // frames: 160 ns bit period, so taken at each fall
   // ----
   task automatic xfer(input int n, input logic [47:0] tx, output logic [47:0] rx,
                       output logic oe);
      rx = '0;
      oe = 1'b1;
      cs_n <= 1'b0;
      repeat (8) @(posedge mclk);
      for (int i = n - 1; i >= 0; i--)
      begin
         si   <= tx[i];
         sclk <= 1'b1;
         repeat (8) @(posedge mclk);
         rx = {rx[46:0], so};
         oe = oe & so_oe;
         sclk <= 1'b0;
         repeat (8) @(posedge mclk);
      end
      cs_n <= 1'b1;
      // released line shows the inverse, not a stale bit
      si   <= ~si;
      repeat (12) @(posedge mclk);
   endtask : xfer
   // line activity while deselected, only on the bench's request
   task automatic noise();
      for (int i = 0; i < 20; i++)
      begin
         sclk <= ~sclk;
         si   <= i[1];
         repeat (5) @(posedge mclk);
      end
      sclk <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : noise
endmodule : spi_host_model

// File: sim/gauge_spi_port_bench.sv
// self-checking bench for the gauge driver serial command port
`include "gauge_spi_params.svh"
module gauge_spi_port_bench import gauge_spi_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic               mclk;
   logic               resetn;
   logic               cs_n;
   logic               sclk;
   logic               si;
   logic               so;
   logic               so_oe;
   logic               commit_pulse;
   logic [2:0]         commit_addr;
   logic [`WORD_W-1:0] status_word;
   gauge_regs_t        regs;
   gauge_regs_t        exp_regs;
   logic [47:0]        rx;
   logic               oe;
   int                 miscompares;
   int                 samples_checked;
   int                 commits;
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   gauge_spi_port uut (.mclk(mclk), .resetn(resetn), .cs_n(cs_n), .sclk(sclk), .si(si),
      .so(so), .so_oe(so_oe), .status_word(status_word), .regs(regs),
      .commit_pulse(commit_pulse), .commit_addr(commit_addr));
   spi_host_model host (.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .si(si), .so(so),
      .so_oe(so_oe));
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         commits <= 0;
      else if (commit_pulse === 1'b1)
         commits <= commits + 1;
   end
   // ----
   // shared checking
   // ----
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic check(input logic [90:0] got, input logic [90:0] want);
      samples_checked++;
      if (got !== want)
      begin
         miscompares++;
         $display("BAD t=%0t got=%h want=%h", $time, got, want);
      end
   endtask : check
   task automatic frame(input int n, input logic [47:0] tx, input int nc);
      int c0;
      c0 = commits;
      host.xfer(n, tx, rx, oe);
      check(regs, exp_regs);
      check(91'(commits - c0), 91'(nc));
      check(91'(oe), 91'h1);
      check(91'(so_oe), 91'h0);
      if (n >= 16)
         check(91'(rx[n-1 -: 16]), 91'(status_word));
   endtask : frame
   // ----
   // scenarios
   // ----
   task automatic map_sweep();
      logic [15:0] w;
      for (int a = 0; a < 7; a++)
      begin
         w = {a[2:0], 13'h1a5 ^ 13'(a * 13'h111)};
         status_word <= 16'hc3a0 + 16'(a);
         exp_regs[(6-a)*13 +: 13] = w[12:0];
         frame(16, 48'(w), 1);
         check(91'(commit_addr), 91'(a));
      end
   endtask : map_sweep
   task automatic null_and_reserved();
      frame(16, 48'h1fff, 1);
      frame(16, 48'hfabc, 1);
      check(91'(commit_addr), 91'h7);
   endtask : null_and_reserved
   task automatic short_frames();
      frame(15, 48'h2123, 0);
      frame(17, 48'h14567, 0);
   endtask : short_frames
   task automatic chain();
      exp_regs.gauge1_target_position = 13'h0777;
      frame(32, 48'h2555_6777, 1);
      check(91'(rx[15:0]), 91'h2555);
   endtask : chain
   task automatic deselected();
      logic so_before;
      so_before = so;
      host.noise();
      check(regs, exp_regs);
      check(91'(so_oe), 91'h0);
      check(91'(so), 91'(so_before));
   endtask : deselected
   task automatic mid_reset();
      resetn <= 1'b0;
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      exp_regs = '0;
      check(regs, exp_regs);
      check(91'(commit_pulse), 91'h0);
      repeat (3) @(posedge mclk);
   endtask : mid_reset
   initial
   begin
      miscompares = 0;
      samples_checked = 0;
      exp_regs = '0;
      resetn = 1'b0;
      status_word = 16'h5a3c;
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      check(regs, exp_regs);
      map_sweep();
      null_and_reserved();
      short_frames();
      chain();
      deselected();
      mid_reset();
      exp_regs.maximum_velocity = 13'h1abc;
      frame(16, 48'h3abc, 1);
      stop_test();
   end
   // whole run is about 4000 cycles; the limit leaves a wide margin
   initial
   begin
      repeat (30000) @(posedge mclk);
      miscompares++;
      stop_test();
   end
endmodule : gauge_spi_port_bench
